//--- hw/startup_config_pkg.sv
package startup_config_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ctrl_offset = 8'h00;
   localparam logic [7:0] status_offset = 8'h04;
   localparam logic [7:0] config_offset = 8'h08;
   localparam logic [7:0] ident_offset = 8'h0C;

   // Control register fields
   localparam int ctrl_restart_bit = 0;
   localparam int ctrl_force_mute_bit = 1;

   // Status register fields
   localparam int status_state_lsb = 0;
   localparam int status_page_bit = 4;
   localparam int status_mute_bit = 5;
   localparam int status_lock_bit = 6;
   localparam int status_reset_pin_bit = 7;

   // Configuration word layout, one word per page
   localparam int cfg_pin8_dir_bit = 0;
   localparam int cfg_pin8_func_lsb = 1;
   localparam int cfg_mode_bit = 3;
   localparam int cfg_prescale_lsb = 4;
   localparam int cfg_mute_default_bit = 6;
   localparam int cfg_width = 16;

   // Pin 8 input function code meaning active-low reset
   localparam logic [1:0] pin8_func_reset = 2'h0;
   localparam logic [1:0] prescale_max = 2'h2;

   // Reset values
   localparam logic [15:0] page0_reset = 16'h0040;
   localparam logic [15:0] page1_reset = 16'h0048;
   localparam logic [1:0] ctrl_reset = 2'h0;

   // Timing counts in cycles of clk_sys (250 MHz)
   localparam int load_cycles = 4;
   localparam int sync_cycles = 8;

   // Sequencer states, Gray along the usual path
   typedef enum logic [3:0] {
      st_off = 4'h0,
      st_load = 4'h1,
      st_apply = 4'h3,
      st_calib = 4'h2,
      st_lock = 4'h6,
      st_sync = 4'h7,
      st_run = 4'h5,
      st_hold = 4'hC
   } seq_state_t;

   // Working copy of a configuration page
   typedef struct packed {
      logic mute_default;
      logic [1:0] prescale;
      logic serial_mode;
      logic [1:0] pin8_function;
      logic pin8_direction;
   } work_cfg_t;

   // Analog handshake group toward the PLL
   typedef struct packed {
      logic calib_start;
      logic divider_sync;
      logic outputs_mute;
   } pll_ctrl_t;

endpackage : startup_config_pkg

//--- hw/sync_two_flop.sv
`timescale 1ns/1ns
`default_nettype none

module sync_two_flop #(
   parameter int width = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);

   logic [width-1:0] stage_one;

   // ----------------------------------------------------------------
   // Two-flop synchroniser; first stage feeds only the second
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stage_one <= '0;
         sync_out <= '0;
      end else begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end

endmodule : sync_two_flop
`default_nettype wire

//--- hw/startup_config_sequencer.sv
// Summary of operation
// - Logic stays idle until power-on release fires, then starts.
// - Chosen page is copied into working registers, then applied.
// - Page-select pin low picks page 0, high picks page 1.
// - Outputs stay muted through VCO calibration and PLL lock by default.
// - After lock, dividers are synchronised first, then outputs released.
// - Pin 8 acts as active-low reset unless configuration reassigns it.
// - Reset pin low holds sequence start and serial interface in reset.
// - Reassigned reset pin: initialisation starts only from power-on release or the control restart bit.
// - Multipurpose pin functions come from the loaded page values.
// - Pin or serial operating mode comes from loaded configuration.
`timescale 1ns/1ns
`default_nettype none

module startup_config_sequencer #(
   parameter int lock_timeout = 65536,
   parameter logic [31:0] ident_value = 32'h5A5A0001 // Arbitrary value
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic por_release,
   input wire logic config_page_select_pin,
   input wire logic active_low_reset_pin,
   input wire logic calib_done,
   input wire logic pll_locked,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic wb_err_o,
   output startup_config_pkg::pll_ctrl_t pll_ctrl,
   output startup_config_pkg::work_cfg_t work_cfg,
   output logic [2:0] vco_divide,
   output logic pin8_direction_choice,
   output logic [1:0] pin8_input_function,
   output logic serial_mode,
   output logic serial_reset
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (lock_timeout < 16) begin : g_bad_timeout
      $error("lock_timeout too small");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   startup_config_pkg::seq_state_t state;
   startup_config_pkg::seq_state_t next_state;
   logic por_sync;
   logic page_sync;
   logic reset_pin_sync;
   logic reset_pin_prev;
   logic por_seen;
   logic reset_active;
   logic reset_released;
   logic page_latched;
   logic [15:0] page_word [2];
   logic [15:0] loaded_word;
   logic [31:0] wait_count;
   logic [1:0] ctrl;
   logic restart_req;
   logic bus_req;
   logic bus_hit;
   logic [31:0] read_mux;

   // Divide ratio from prescale setting
   function automatic logic [2:0] prescale_divide(input logic [1:0] setting);
      prescale_divide = {1'b0, setting} + 3'h4;
   endfunction : prescale_divide

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   sync_two_flop #(.width(3)) u_pin_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in({por_release, config_page_select_pin, active_low_reset_pin}),
      .sync_out({por_sync, page_sync, reset_pin_sync})
   );

   // ----------------------------------------------------------------
   // Reset pin interpretation
   // ----------------------------------------------------------------
   // Before any page loads pin 8 acts as reset; afterwards the page decides
   assign reset_active = por_seen && !reset_pin_sync &&
      (work_cfg.pin8_function == startup_config_pkg::pin8_func_reset);
   assign reset_released = por_seen && reset_pin_sync && !reset_pin_prev &&
      (work_cfg.pin8_function == startup_config_pkg::pin8_func_reset);

   // Edge history of the reset pin, and power-on release latch
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reset_pin_prev <= 1'b1;
         por_seen <= 1'b0;
      end else begin
         reset_pin_prev <= reset_pin_sync;
         if (por_sync) begin
            por_seen <= 1'b1;
         end
      end
   end

   // Serial interface held while the reset pin is active
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         serial_reset <= 1'b1;
      end else begin
         serial_reset <= !por_seen || reset_active;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer state register and cycle counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= startup_config_pkg::st_off;
      end else begin
         state <= next_state;
      end
   end

   // Counter restarts on every state change
   always_ff @(posedge clk_sys) begin
      if (rst || next_state != state) begin
         wait_count <= '0;
      end else if (wait_count != 32'hFFFFFFFF) begin
         wait_count <= wait_count + 32'h1;
      end
   end

   // Next-state decision; outside st_off the reset pin wins over every other cause
   always_comb begin
      next_state = state;
      case (state)
         startup_config_pkg::st_off: begin
            if (por_seen) begin
               next_state = startup_config_pkg::st_load;
            end
         end
         startup_config_pkg::st_load: begin
            if (wait_count >= 32'(startup_config_pkg::load_cycles - 1)) begin
               next_state = startup_config_pkg::st_apply;
            end
         end
         startup_config_pkg::st_apply: begin
            next_state = startup_config_pkg::st_calib;
         end
         startup_config_pkg::st_calib: begin
            if (calib_done) begin
               next_state = startup_config_pkg::st_lock;
            end
         end
         startup_config_pkg::st_lock: begin
            // A stuck lock recalibrates rather than hanging forever
            if (pll_locked) begin
               next_state = startup_config_pkg::st_sync;
            end else if (wait_count >= 32'(lock_timeout)) begin
               next_state = startup_config_pkg::st_calib;
            end
         end
         startup_config_pkg::st_sync: begin
            if (wait_count >= 32'(startup_config_pkg::sync_cycles - 1)) begin
               next_state = startup_config_pkg::st_run;
            end
         end
         startup_config_pkg::st_run: begin
            if (!pll_locked) begin
               next_state = startup_config_pkg::st_calib;
            end
         end
         startup_config_pkg::st_hold: begin
            if (!reset_active) begin
               next_state = startup_config_pkg::st_load;
            end
         end
         default: next_state = startup_config_pkg::st_off;
      endcase
      if (reset_active && state != startup_config_pkg::st_off) begin
         next_state = startup_config_pkg::st_hold;
      end else if ((restart_req || reset_released) &&
                   state != startup_config_pkg::st_off &&
                   state != startup_config_pkg::st_hold) begin
         next_state = startup_config_pkg::st_load;
      end
   end

   // ----------------------------------------------------------------
   // Page storage and load
   // ----------------------------------------------------------------
   // Pages written over the bus stand in for the nonvolatile array
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         page_word[0] <= startup_config_pkg::page0_reset;
         page_word[1] <= startup_config_pkg::page1_reset;
      end else if (bus_req && bus_hit && wb_we_i &&
                   wb_adr_i[7:0] == startup_config_pkg::config_offset) begin
         if (wb_sel_i[0]) begin
            page_word[0][7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            page_word[0][15:8] <= wb_dat_i[15:8];
         end
         if (wb_sel_i[2]) begin
            page_word[1][7:0] <= wb_dat_i[23:16];
         end
         if (wb_sel_i[3]) begin
            page_word[1][15:8] <= wb_dat_i[31:24];
         end
      end
   end

   // Page chosen by the pin level at load time
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         page_latched <= 1'b0;
         loaded_word <= '0;
      end else if (state == startup_config_pkg::st_load && wait_count == 32'h0) begin
         page_latched <= page_sync;
         loaded_word <= page_word[page_sync];
      end
   end

   // Working registers take effect at the apply step
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         work_cfg <= '0;
      end else if (state == startup_config_pkg::st_apply) begin
         work_cfg.pin8_direction <= loaded_word[startup_config_pkg::cfg_pin8_dir_bit];
         work_cfg.pin8_function <= loaded_word[startup_config_pkg::cfg_pin8_func_lsb +: 2];
         work_cfg.serial_mode <= loaded_word[startup_config_pkg::cfg_mode_bit];
         work_cfg.prescale <= loaded_word[startup_config_pkg::cfg_prescale_lsb +: 2];
         work_cfg.mute_default <= loaded_word[startup_config_pkg::cfg_mute_default_bit];
      end
   end

   // ----------------------------------------------------------------
   // Outputs toward the PLL and pins
   // ----------------------------------------------------------------
   // Out-of-range prescale is software's fault; clamp so divide stays 4..6
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         vco_divide <= prescale_divide(2'h0);
      end else if (work_cfg.prescale > startup_config_pkg::prescale_max) begin
         vco_divide <= prescale_divide(startup_config_pkg::prescale_max);
      end else begin
         vco_divide <= prescale_divide(work_cfg.prescale);
      end
   end

   // Mute, calibration and sync strobes follow the sequencer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pll_ctrl <= '{calib_start: 1'b0, divider_sync: 1'b0, outputs_mute: 1'b1};
      end else begin
         pll_ctrl.calib_start <= (next_state == startup_config_pkg::st_calib);
         pll_ctrl.divider_sync <= (next_state == startup_config_pkg::st_sync);
         // Mute bit off only lets outputs run before lock when asked for
         // Apply step stays muted: the new page's mute bit lands one edge late
         pll_ctrl.outputs_mute <= ctrl[startup_config_pkg::ctrl_force_mute_bit] ||
            (next_state != startup_config_pkg::st_run &&
             (work_cfg.mute_default || next_state == startup_config_pkg::st_off ||
              next_state == startup_config_pkg::st_hold ||
              next_state == startup_config_pkg::st_load ||
              next_state == startup_config_pkg::st_apply ||
              state == startup_config_pkg::st_apply));
      end
   end

   // Pin function outputs from working registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin8_direction_choice <= 1'b0;
         pin8_input_function <= startup_config_pkg::pin8_func_reset;
         serial_mode <= 1'b0;
      end else begin
         pin8_direction_choice <= work_cfg.pin8_direction;
         pin8_input_function <= work_cfg.pin8_function;
         serial_mode <= work_cfg.serial_mode;
      end
   end

   // ----------------------------------------------------------------
   // Wishbone classic slave
   // ----------------------------------------------------------------
   // Bus refused while serial side is in reset
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !serial_reset;
   assign bus_hit = wb_adr_i[31:8] == 24'h0 && wb_adr_i[1:0] == 2'h0 &&
      (wb_adr_i[7:0] == startup_config_pkg::ctrl_offset ||
       wb_adr_i[7:0] == startup_config_pkg::status_offset ||
       wb_adr_i[7:0] == startup_config_pkg::config_offset ||
       wb_adr_i[7:0] == startup_config_pkg::ident_offset);

   // Read data selection
   always_comb begin
      read_mux = 32'h0;
      case (wb_adr_i[7:0])
         startup_config_pkg::ctrl_offset: read_mux = {30'h0, ctrl};
         startup_config_pkg::status_offset: read_mux = {24'h0, reset_pin_sync,
            pll_locked, pll_ctrl.outputs_mute, page_latched, state};
         startup_config_pkg::config_offset: read_mux = {page_word[1], page_word[0]};
         startup_config_pkg::ident_offset: read_mux = ident_value;
         default: read_mux = 32'h0;
      endcase
   end

   // One-cycle answer, dropped the cycle after
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= bus_req && bus_hit;
         wb_err_o <= bus_req && !bus_hit;
         wb_dat_o <= (bus_req && bus_hit && !wb_we_i) ? read_mux : 32'h0;
      end
   end

   // Control register; restart bit self-clears
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl <= startup_config_pkg::ctrl_reset;
         restart_req <= 1'b0;
      end else begin
         restart_req <= 1'b0;
         if (bus_req && bus_hit && wb_we_i && wb_sel_i[0] &&
             wb_adr_i[7:0] == startup_config_pkg::ctrl_offset) begin
            ctrl[startup_config_pkg::ctrl_force_mute_bit] <= wb_dat_i[1];
            restart_req <= wb_dat_i[startup_config_pkg::ctrl_restart_bit];
         end
      end
   end

endmodule : startup_config_sequencer
`default_nettype wire

//--- testbench/startup_config_sequencer_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module startup_config_sequencer_assertions (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic por_release,
   input wire logic active_low_reset_pin,
   input wire logic pll_locked,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire startup_config_pkg::pll_ctrl_t pll_ctrl,
   input wire startup_config_pkg::work_cfg_t work_cfg,
   input wire logic [2:0] vco_divide,
   input wire logic pin8_direction_choice,
   input wire logic [1:0] pin8_input_function,
   input wire logic serial_mode,
   input wire logic serial_reset
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // Startup sequence
   // ----------------------------------------------------------------
   // Divider sync window is a fixed eight cycles
   sequence sync_window;
      pll_ctrl.divider_sync [*8] ##1 !pll_ctrl.divider_sync;
   endsequence
   // Reset pin held low long enough to pass the synchroniser
   sequence pin_held;
      (!active_low_reset_pin && pin8_input_function == 2'h0) [*6];
   endsequence

   chk_por_gate: assert property (!por_release [*4] |-> serial_reset && !pll_ctrl.calib_start)
      else $error("sequencer active before power-on release");
   chk_mute_calib: assert property (pll_ctrl.calib_start && work_cfg.mute_default |-> pll_ctrl.outputs_mute)
      else $error("outputs live during calibration");
   chk_sync_len: assert property ($rose(pll_ctrl.divider_sync) |-> sync_window)
      else $error("divider sync window length wrong");
   chk_sync_locked: assert property (pll_ctrl.divider_sync |-> pll_locked)
      else $error("divider sync without lock");
   chk_release_order: assert property ($fell(pll_ctrl.outputs_mute) && work_cfg.mute_default
      |-> $past(pll_ctrl.divider_sync) || $past(pll_ctrl.divider_sync, 2))
      else $error("outputs released without divider sync");
   chk_pin_hold: assert property (pin_held |-> serial_reset && pll_ctrl.outputs_mute)
      else $error("reset pin low did not hold the sequencer");
   chk_pin8_copy: assert property (1'b1 |=> pin8_input_function == $past(work_cfg.pin8_function)
      && pin8_direction_choice == $past(work_cfg.pin8_direction))
      else $error("pin 8 setup not taken from the page");
   chk_mode_copy: assert property (1'b1 |=> serial_mode == $past(work_cfg.serial_mode))
      else $error("operating mode not taken from the page");
   chk_divide_map: assert property ($stable(work_cfg.prescale) && work_cfg.prescale <= 2'h2
      |-> vco_divide == {1'b0, work_cfg.prescale} + 3'h4)
      else $error("prescale divide not setting plus four");
   // Bus is silent while the serial side is held in reset
   chk_bus_refused: assert property (serial_reset |=> !wb_ack_o && !wb_err_o)
      else $error("bus answered while serial side in reset");
endmodule : startup_config_sequencer_assertions

bind startup_config_sequencer startup_config_sequencer_assertions u_startup_config_sequencer_assertions (
   .clk_sys(clk_sys), .rst(rst), .por_release(por_release), .pll_locked(pll_locked),
   .active_low_reset_pin(active_low_reset_pin), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .pll_ctrl(pll_ctrl), .work_cfg(work_cfg), .vco_divide(vco_divide),
   .pin8_direction_choice(pin8_direction_choice), .pin8_input_function(pin8_input_function),
   .serial_mode(serial_mode), .serial_reset(serial_reset));

`default_nettype wire

//--- testbench/board_side_model.sv
`timescale 1ns/1ns
`default_nettype none

module board_side_model (
   input wire logic clk_sys,
   input wire logic calib_start,
   input wire logic slow,
   input wire logic por_req,
   input wire logic page_req,
   input wire logic reset_req,
   output logic por_release = 1'b0,
   output logic config_page_select_pin = 1'b0,
   output logic active_low_reset_pin = 1'b1,
   output logic calib_done = 1'b0,
   output logic pll_locked = 1'b0
);
   logic [5:0] calib_cnt = 6'h00;
   logic [5:0] lock_cnt = 6'h00;
   logic armed = 1'b0;

   // Board pins follow requests; reset pin is driven active low
   always_ff @(posedge clk_sys) begin
      por_release <= por_req;
      config_page_select_pin <= page_req;
      active_low_reset_pin <= !reset_req;
   end

   // Calibration ends after a short or a long wait, drops when released
   always_ff @(posedge clk_sys) begin
      if (!calib_start) begin
         calib_cnt <= 6'h00;
         calib_done <= 1'b0;
      end else if (calib_cnt == (slow ? 6'h14 : 6'h03)) begin
         calib_done <= 1'b1;
      end else begin
         calib_cnt <= calib_cnt + 6'h01;
      end
   end

   // Lock only after a finished calibration; lost on recalibration
   always_ff @(posedge clk_sys) begin
      if (calib_start && !calib_done) begin
         armed <= 1'b0;
         lock_cnt <= 6'h00;
         pll_locked <= 1'b0;
      end else if (calib_done || armed) begin
         armed <= 1'b1;
         if (lock_cnt == (slow ? 6'h14 : 6'h02)) pll_locked <= 1'b1;
         else lock_cnt <= lock_cnt + 6'h01;
      end
   end
endmodule : board_side_model

`default_nettype wire

//--- testbench/tb_startup_config_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

module tb_startup_config_sequencer;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic por_req = 1'b0, page_req = 1'b0, reset_req = 1'b0, slow = 1'b0;
   logic por_release, config_page_select_pin, active_low_reset_pin, calib_done, pll_locked;
   logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, wb_err_o;
   startup_config_pkg::pll_ctrl_t pll_ctrl;
   startup_config_pkg::work_cfg_t work_cfg;
   logic [2:0] vco_divide;
   logic pin8_direction_choice, serial_mode, serial_reset;
   logic [1:0] pin8_input_function;
   logic [31:0] rd;
   logic er;
   int err_total = 0, checks_done = 0, cycles = 0;

   // ----------------------------------------------------------------
   // Design, board side and clock
   // ----------------------------------------------------------------
   startup_config_sequencer #(.lock_timeout(32)) u_startup_config_sequencer (
      .clk_sys(clk_sys), .rst(rst), .por_release(por_release),
      .config_page_select_pin(config_page_select_pin), .active_low_reset_pin(active_low_reset_pin),
      .calib_done(calib_done), .pll_locked(pll_locked), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .pll_ctrl(pll_ctrl), .work_cfg(work_cfg), .vco_divide(vco_divide),
      .pin8_direction_choice(pin8_direction_choice), .pin8_input_function(pin8_input_function),
      .serial_mode(serial_mode), .serial_reset(serial_reset));
   board_side_model u_board_side_model (
      .clk_sys(clk_sys), .calib_start(pll_ctrl.calib_start), .slow(slow), .por_req(por_req),
      .page_req(page_req), .reset_req(reset_req), .por_release(por_release),
      .config_page_select_pin(config_page_select_pin),
      .active_low_reset_pin(active_low_reset_pin), .calib_done(calib_done),
      .pll_locked(pll_locked));

   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic conclude;
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : check

   // Classic cycle; answer sampled at the rising edge, released right after it
   task automatic wb_xfer(input logic [31:0] adr, input logic we, input logic [31:0] dat,
                          input logic [3:0] sel);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_adr_i <= adr;
      wb_we_i <= we;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 100);
      check("bus answer", 32'h1, {31'h0, n < 100});
      rd = wb_dat_o;
      er = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb_xfer

   // Bounded wait for the output mute to reach a level
   task automatic wait_mute(input logic lvl, input int lim);
      int n;
      n = 0;
      while (pll_ctrl.outputs_mute !== lvl && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      check("mute level reached", 32'h1, {31'h0, n < lim});
   endtask : wait_mute

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic s_por_gate;
      repeat (20) @(negedge clk_sys);
      check("serial reset before por", 32'h1, {31'h0, serial_reset});
      check("calib before por", 32'h0, {31'h0, pll_ctrl.calib_start});
   endtask : s_por_gate

   task automatic s_boot_page0;
      por_req <= 1'b1;
      wait_mute(1'b0, 300);
      wb_xfer(startup_config_pkg::status_offset, 1'b0, 32'h0, 4'hF);
      check("state page0", 32'h05, {27'h0, rd[4:0]});
      wb_xfer(startup_config_pkg::config_offset, 1'b0, 32'h0, 4'hF);
      check("page words", 32'h00480040, rd);
      check("work cfg page0", 32'h40, {25'h0, work_cfg});
      check("mode page0", 32'h0, {31'h0, serial_mode});
   endtask : s_boot_page0

   // Pin reset with page 1 selected and a slow PLL; full restart expected
   task automatic s_pin_restart;
      slow <= 1'b1;
      page_req <= 1'b1;
      reset_req <= 1'b1;
      repeat (10) @(negedge clk_sys);
      check("serial held", 32'h1, {31'h0, serial_reset});
      check("muted in hold", 32'h1, {31'h0, pll_ctrl.outputs_mute});
      @(posedge clk_sys);
      reset_req <= 1'b0;
      wait_mute(1'b0, 600);
      wb_xfer(startup_config_pkg::status_offset, 1'b0, 32'h0, 4'hF);
      check("state page1", 32'h15, {27'h0, rd[4:0]});
      check("work cfg page1", 32'h48, {25'h0, work_cfg});
      check("mode page1", 32'h1, {31'h0, serial_mode});
   endtask : s_pin_restart

   // Page 0 rewritten: pin 8 leaves reset duty, prescale at its top value
   task automatic s_reassign;
      slow <= 1'b0;
      page_req <= 1'b0;
      wb_xfer(startup_config_pkg::config_offset, 1'b1, 32'h00480063, 4'h3);
      wb_xfer(startup_config_pkg::ctrl_offset, 1'b1, 32'h1, 4'h1);
      wait_mute(1'b1, 50);
      wait_mute(1'b0, 300);
      check("vco divide", 32'h6, {29'h0, vco_divide});
      check("pin8 function", 32'h1, {30'h0, pin8_input_function});
      check("pin8 direction", 32'h1, {31'h0, pin8_direction_choice});
      reset_req <= 1'b1;
      repeat (10) @(negedge clk_sys);
      check("pin ignored", 32'h0, {31'h0, serial_reset});
      wb_xfer(startup_config_pkg::status_offset, 1'b0, 32'h0, 4'hF);
      check("still running", 32'h5, {28'h0, rd[3:0]});
      reset_req <= 1'b0;
      wb_xfer(32'h00000010, 1'b0, 32'h0, 4'hF);
      check("unmapped error", 32'h1, {31'h0, er});
   endtask : s_reassign

   // ----------------------------------------------------------------
   // Main sequence and hang guard
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      s_por_gate;
      s_boot_page0;
      s_pin_restart;
      s_reassign;
      conclude;
   end

   // Whole run needs a few hundred cycles; far above that is a hang
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         conclude;
      end
   end
endmodule : tb_startup_config_sequencer

`default_nettype wire
